// File: logic/accu_ops_regs.vh
// constants for the accumulator and X register opcode block
`ifndef ACCU_OPS_REGS_VH
`define ACCU_OPS_REGS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_ACCU 8'h08
`define OFF_XREG 8'h0c
`define OFF_FLAGS 8'h10
`define OFF_IRQ_STATUS 8'h14
`define OFF_IRQ_CLEAR 8'h18
`define OFF_IRQ_ENABLE 8'h1c

// ----------------------------------------
// control and status fields
// ----------------------------------------
`define CTRL_RUN_BIT 0
`define CTRL_HALT_BIT 1
`define STATUS_RUNNING_BIT 0
`define STATUS_BUSY_BIT 1
`define STATUS_FRAME_BIT 2

// ----------------------------------------
// interrupt events
// ----------------------------------------
`define IRQ_STOP_BIT 0
`define IRQ_CSUM_BIT 1
`define IRQ_DONE_BIT 2
`define IRQ_TIMEOUT_BIT 3
`define IRQ_WIDTH 4

// ----------------------------------------
// opcodes
// ----------------------------------------
`define OP_STOP 8'h1c
`define OP_XCALC 8'h21
`define OP_TO_AXIS 8'h22
`define OP_TO_GLOBAL 8'h23
`define OP_CLEAR_FLAGS 8'h24
`define OP_RESET_APP 8'h83

// ----------------------------------------
// compute types
// ----------------------------------------
`define XT_ADD 8'h00
`define XT_SUB 8'h01
`define XT_MUL 8'h02
`define XT_DIV 8'h03
`define XT_MOD 8'h04
`define XT_AND 8'h05
`define XT_OR 8'h06
`define XT_XOR 8'h07
`define XT_NOT 8'h08
`define XT_LOAD 8'h09
`define XT_SWAP 8'h0a

// ----------------------------------------
// flag bits and clear types
// ----------------------------------------
`define FLAG_TIMEOUT 0
`define FLAG_ALARM 1
`define FLAG_DEVIATION 2
`define FLAG_POSITION 3
`define FLAG_SHUTDOWN 4
`define FLAG_WIDTH 5
`define CLR_ALL 8'h00
`define CLR_LAST 8'h05

// ----------------------------------------
// replies, frames and reset values
// ----------------------------------------
`define STAT_OK 8'h64
`define STAT_BAD_CSUM 8'h01
`define STAT_BAD_CMD 8'h02
`define STAT_BAD_BANK 8'h04
`define FRAME_LAST 4'h8
`define BANK_0 8'h00
`define BANK_2 8'h02
`define BANK_3 8'h03
`define RST_WORD 32'h0000_0000

`endif

// File: logic/signed_divider.v
// sequential signed divider, truncating quotient, remainder takes dividend sign
`timescale 1ns/1ps
`default_nettype none

module signed_divider #(
	parameter WIDTH = 32
) (
	input wire hclk,
	input wire hresetn,
	input wire start,
	input wire [WIDTH-1:0] dividend,
	input wire [WIDTH-1:0] divisor,
	output reg done,
	output reg [WIDTH-1:0] quotient,
	output reg [WIDTH-1:0] remainder
);

	reg [WIDTH-1:0] quo_reg;
	reg [WIDTH:0] rem_reg;
	reg [WIDTH-1:0] den_reg;
	reg [6:0] count_reg;
	reg busy_reg;
	reg neg_q_reg;
	reg neg_r_reg;
	wire [WIDTH:0] trial;

	// one quotient bit per cycle: small area, WIDTH+1 cycles latency
	assign trial = {rem_reg[WIDTH-1:0], quo_reg[WIDTH-1]} - {1'b0, den_reg};

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			quo_reg <= {WIDTH{1'b0}};
			rem_reg <= {(WIDTH+1){1'b0}};
			den_reg <= {WIDTH{1'b0}};
			count_reg <= 7'h00;
			busy_reg <= 1'b0;
			neg_q_reg <= 1'b0;
			neg_r_reg <= 1'b0;
			done <= 1'b0;
			quotient <= {WIDTH{1'b0}};
			remainder <= {WIDTH{1'b0}};
		end
		else
		begin
			done <= 1'b0;
			if (start && !busy_reg)
			begin
				busy_reg <= 1'b1;
				count_reg <= WIDTH[6:0];
				quo_reg <= dividend[WIDTH-1] ? (~dividend + 1'b1) : dividend;
				den_reg <= divisor[WIDTH-1] ? (~divisor + 1'b1) : divisor;
				rem_reg <= {(WIDTH+1){1'b0}};
				neg_q_reg <= dividend[WIDTH-1] ^ divisor[WIDTH-1];
				neg_r_reg <= dividend[WIDTH-1];
			end
			else if (busy_reg && count_reg != 7'h00)
			begin
				count_reg <= count_reg - 7'h01;
				if (!trial[WIDTH])
				begin
					rem_reg <= trial;
					quo_reg <= {quo_reg[WIDTH-2:0], 1'b1};
				end
				else
				begin
					rem_reg <= {rem_reg[WIDTH-1:0], quo_reg[WIDTH-1]};
					quo_reg <= {quo_reg[WIDTH-2:0], 1'b0};
				end
			end
			else if (busy_reg)
			begin
				busy_reg <= 1'b0;
				done <= 1'b1;
				quotient <= neg_q_reg ? (~quo_reg + 1'b1) : quo_reg;
				remainder <= neg_r_reg ? (~rem_reg[WIDTH-1:0] + 1'b1) : rem_reg[WIDTH-1:0];
			end
		end
	end

endmodule

`default_nettype wire

// File: logic/script_vm_accu_ops.v
// accumulator / X register opcode executor with frame receiver and AHB-Lite registers
//
// Register access over AHB-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "accu_ops_regs.vh"

module script_vm_accu_ops #(
	parameter [7:0] MODULE_ADDR = 8'h01
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire hready,
	input wire [31:0] hwdata,
	output reg [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	input wire rx_valid,
	input wire [7:0] rx_byte,
	output wire rx_ready,
	output reg reply_valid,
	output reg [7:0] reply_status,
	output reg [7:0] reply_opcode,
	input wire prog_valid,
	input wire [7:0] prog_opcode,
	input wire [7:0] prog_type,
	input wire [7:0] prog_bank,
	input wire [31:0] prog_value,
	output wire prog_ready,
	output reg prog_running,
	output reg prog_reset,
	output reg axis_wr,
	output reg [7:0] axis_index,
	output reg [7:0] axis_motor,
	output reg [31:0] axis_data,
	output reg global_wr,
	output reg [7:0] global_index,
	output reg [7:0] global_bank,
	output reg [31:0] global_data,
	input wire wait_timeout,
	input wire alarm_event,
	input wire deviation_event,
	input wire position_event,
	input wire shutdown_event,
	output reg [`FLAG_WIDTH-1:0] error_flags,
	output wire irq
);

	localparam ST_IDLE = 1'b0;
	localparam ST_DIV = 1'b1;

	reg state_reg;
	reg [31:0] accu_reg;
	reg [31:0] xreg_reg;
	reg [7:0] op_reg;
	reg [7:0] type_reg;
	reg direct_reg;
	reg [3:0] idx_reg;
	reg [7:0] sum_reg;
	reg [7:0] f_addr_reg;
	reg [7:0] f_op_reg;
	reg [7:0] f_type_reg;
	reg [7:0] f_bank_reg;
	reg [31:0] f_value_reg;
	reg frame_pending_reg;
	reg [`IRQ_WIDTH-1:0] irq_status_reg;
	reg [`IRQ_WIDTH-1:0] irq_enable_reg;
	reg wr_pend_reg;
	reg [7:0] wr_addr_reg;
	reg [`IRQ_WIDTH-1:0] irq_set;
	reg [`FLAG_WIDTH-1:0] flag_clr;
	reg [31:0] accu_next;
	reg [31:0] xreg_next;
	reg div_start;
	wire div_done;
	wire [31:0] div_quo;
	wire [31:0] div_rem;
	wire take_frame;
	wire take_prog;
	wire take;
	wire [7:0] c_op;
	wire [7:0] c_type;
	wire [7:0] c_bank;
	wire [31:0] c_value;
	wire [63:0] product;
	wire bus_req;
	wire bus_wr;
	wire [`FLAG_WIDTH-1:0] flag_set;

	// ----------------------------------------
	// frame receiver
	// ----------------------------------------
	assign rx_ready = !frame_pending_reg;

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			idx_reg <= 4'h0;
			sum_reg <= 8'h00;
			f_addr_reg <= 8'h00;
			f_op_reg <= 8'h00;
			f_type_reg <= 8'h00;
			f_bank_reg <= 8'h00;
			f_value_reg <= `RST_WORD;
			frame_pending_reg <= 1'b0;
		end
		else
		begin
			if (take_frame)
				frame_pending_reg <= 1'b0;
			if (rx_valid && rx_ready)
			begin
				case (idx_reg)
					4'h0: f_addr_reg <= rx_byte;
					4'h1: f_op_reg <= rx_byte;
					4'h2: f_type_reg <= rx_byte;
					4'h3: f_bank_reg <= rx_byte;
					4'h4, 4'h5, 4'h6, 4'h7: f_value_reg <= {f_value_reg[23:0], rx_byte};
					default: f_value_reg <= f_value_reg;
				endcase
				if (idx_reg == `FRAME_LAST)
				begin
					idx_reg <= 4'h0;
					sum_reg <= 8'h00;
					// frames for other addresses are dropped silently
					if (rx_byte == sum_reg && f_addr_reg == MODULE_ADDR)
						frame_pending_reg <= 1'b1;
				end
				else
				begin
					idx_reg <= idx_reg + 4'h1;
					sum_reg <= sum_reg + rx_byte;
				end
			end
		end
	end

	// ----------------------------------------
	// command selection: direct frames before program
	// ----------------------------------------
	assign take_frame = frame_pending_reg && state_reg == ST_IDLE;
	assign take_prog = !frame_pending_reg && prog_running && prog_valid && state_reg == ST_IDLE;
	assign prog_ready = !frame_pending_reg && prog_running && state_reg == ST_IDLE;
	assign take = take_frame || take_prog;
	assign c_op = take_frame ? f_op_reg : prog_opcode;
	assign c_type = take_frame ? f_type_reg : prog_type;
	assign c_bank = take_frame ? f_bank_reg : prog_bank;
	assign c_value = take_frame ? f_value_reg : prog_value;
	assign product = $signed(accu_reg) * $signed(xreg_reg);

	always @*
	begin
		accu_next = accu_reg;
		xreg_next = xreg_reg;
		div_start = 1'b0;
		if (take && c_op == `OP_XCALC)
		begin
			case (c_type)
				`XT_ADD: accu_next = accu_reg + xreg_reg;
				`XT_SUB: accu_next = accu_reg - xreg_reg;
				`XT_MUL: accu_next = product[31:0];
				`XT_DIV, `XT_MOD: div_start = xreg_reg != `RST_WORD;
				`XT_AND: accu_next = accu_reg & xreg_reg;
				`XT_OR: accu_next = accu_reg | xreg_reg;
				`XT_XOR: accu_next = accu_reg ^ xreg_reg;
				`XT_NOT: accu_next = ~xreg_reg;
				`XT_LOAD: xreg_next = accu_reg;
				`XT_SWAP:
				begin
					accu_next = xreg_reg;
					xreg_next = accu_reg;
				end
				default: accu_next = accu_reg;
			endcase
		end
		else if (state_reg == ST_DIV && div_done)
			accu_next = (type_reg == `XT_DIV) ? div_quo : div_rem;
		if (bus_wr && wr_addr_reg == `OFF_ACCU && !take && state_reg == ST_IDLE)
			accu_next = hwdata;
		if (bus_wr && wr_addr_reg == `OFF_XREG && !take && state_reg == ST_IDLE)
			xreg_next = hwdata;
		if (take && c_op == `OP_RESET_APP)
		begin
			accu_next = `RST_WORD;
			xreg_next = `RST_WORD;
		end
	end

	signed_divider #(
		.WIDTH(32)
	) u_div (
		.hclk(hclk),
		.hresetn(hresetn),
		.start(div_start),
		.dividend(accu_reg),
		.divisor(xreg_reg),
		.done(div_done),
		.quotient(div_quo),
		.remainder(div_rem)
	);

	// ----------------------------------------
	// execution and replies
	// ----------------------------------------
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_reg <= ST_IDLE;
			accu_reg <= `RST_WORD;
			xreg_reg <= `RST_WORD;
			op_reg <= 8'h00;
			type_reg <= 8'h00;
			direct_reg <= 1'b0;
			reply_valid <= 1'b0;
			reply_status <= 8'h00;
			reply_opcode <= 8'h00;
			prog_running <= 1'b0;
			prog_reset <= 1'b0;
			axis_wr <= 1'b0;
			axis_index <= 8'h00;
			axis_motor <= 8'h00;
			axis_data <= `RST_WORD;
			global_wr <= 1'b0;
			global_index <= 8'h00;
			global_bank <= 8'h00;
			global_data <= `RST_WORD;
		end
		else
		begin
			accu_reg <= accu_next;
			xreg_reg <= xreg_next;
			reply_valid <= 1'b0;
			prog_reset <= 1'b0;
			axis_wr <= 1'b0;
			global_wr <= 1'b0;
			if (bus_wr && wr_addr_reg == `OFF_CTRL && hwdata[`CTRL_RUN_BIT])
				prog_running <= 1'b1;
			if (bus_wr && wr_addr_reg == `OFF_CTRL && hwdata[`CTRL_HALT_BIT])
				prog_running <= 1'b0;
			case (state_reg)
				ST_IDLE:
				begin
					if (take)
					begin
						op_reg <= c_op;
						type_reg <= c_type;
						direct_reg <= take_frame;
						reply_opcode <= c_op;
						reply_valid <= take_frame;
						reply_status <= `STAT_OK;
						case (c_op)
							`OP_STOP: prog_running <= 1'b0;
							`OP_XCALC:
							begin
								if (div_start)
								begin
									reply_valid <= 1'b0;
									state_reg <= ST_DIV;
								end
							end
							`OP_TO_AXIS:
							begin
								axis_wr <= 1'b1;
								axis_index <= c_type;
								axis_motor <= c_bank;
								axis_data <= accu_reg;
							end
							`OP_TO_GLOBAL:
							begin
								if (c_bank == `BANK_0 || c_bank == `BANK_2 || c_bank == `BANK_3)
								begin
									global_wr <= 1'b1;
									global_index <= c_type;
									global_bank <= c_bank;
									global_data <= accu_reg;
								end
								else
									reply_status <= `STAT_BAD_BANK;
							end
							`OP_CLEAR_FLAGS: reply_status <= `STAT_OK;
							`OP_RESET_APP:
							begin
								prog_running <= 1'b0;
								prog_reset <= 1'b1;
							end
							default: reply_status <= `STAT_BAD_CMD;
						endcase
					end
				end
				ST_DIV:
				begin
					if (div_done)
					begin
						state_reg <= ST_IDLE;
						reply_valid <= direct_reg;
						reply_status <= `STAT_OK;
						reply_opcode <= op_reg;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// error flags: an event in the clearing cycle survives
	// ----------------------------------------
	assign flag_set = {shutdown_event, position_event, deviation_event, alarm_event, wait_timeout};

	always @*
	begin
		flag_clr = {`FLAG_WIDTH{1'b0}};
		if (take && c_op == `OP_RESET_APP)
			flag_clr = {`FLAG_WIDTH{1'b1}};
		else if (take && c_op == `OP_CLEAR_FLAGS)
		begin
			if (c_type == `CLR_ALL)
				flag_clr = {`FLAG_WIDTH{1'b1}};
			else if (c_type <= `CLR_LAST)
				flag_clr[c_type[2:0] - 3'h1] = 1'b1;
		end
	end

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			error_flags <= {`FLAG_WIDTH{1'b0}};
		else
			error_flags <= (error_flags & ~flag_clr) | flag_set;
	end

	// ----------------------------------------
	// AHB-Lite slave, zero wait states
	// ----------------------------------------
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign bus_req = hsel && hready && htrans[1];
	assign bus_wr = wr_pend_reg;

	always @*
	begin
		irq_set = {`IRQ_WIDTH{1'b0}};
		irq_set[`IRQ_STOP_BIT] = take && c_op == `OP_STOP;
		irq_set[`IRQ_CSUM_BIT] = rx_valid && rx_ready && idx_reg == `FRAME_LAST && rx_byte != sum_reg;
		irq_set[`IRQ_DONE_BIT] = reply_valid;
		irq_set[`IRQ_TIMEOUT_BIT] = wait_timeout;
	end

	assign irq = |(irq_status_reg & irq_enable_reg);

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			hrdata <= `RST_WORD;
			irq_status_reg <= {`IRQ_WIDTH{1'b0}};
			irq_enable_reg <= {`IRQ_WIDTH{1'b0}};
		end
		else
		begin
			wr_pend_reg <= bus_req && hwrite;
			wr_addr_reg <= haddr[7:0];
			if (bus_wr && wr_addr_reg == `OFF_IRQ_ENABLE)
				irq_enable_reg <= hwdata[`IRQ_WIDTH-1:0];
			if (bus_wr && wr_addr_reg == `OFF_IRQ_CLEAR)
				irq_status_reg <= (irq_status_reg & ~hwdata[`IRQ_WIDTH-1:0]) | irq_set;
			else
				irq_status_reg <= irq_status_reg | irq_set;
			hrdata <= `RST_WORD;
			if (bus_req && !hwrite)
			begin
				case (haddr[7:0])
					`OFF_STATUS: hrdata <= {29'h0, frame_pending_reg, state_reg, prog_running};
					`OFF_ACCU: hrdata <= accu_reg;
					`OFF_XREG: hrdata <= xreg_reg;
					`OFF_FLAGS: hrdata <= {27'h0, error_flags};
					`OFF_IRQ_STATUS: hrdata <= {28'h0, irq_status_reg};
					`OFF_IRQ_ENABLE: hrdata <= {28'h0, irq_enable_reg};
					default: hrdata <= `RST_WORD;
				endcase
			end
		end
	end

endmodule

`default_nettype wire

// File: testbench/host_frame_model.sv
// host model that sends nine-byte command frames
`timescale 1ns/1ps
`default_nettype none
module host_frame_model (
	input wire logic hclk,
	input wire logic rx_ready,
	output logic rx_valid = 1'b0,
	output logic [7:0] rx_byte = 8'h00
);
	// ----------------
	// frame sender
	// ----------------
	// gap above zero idles between bytes, acting as a slow host
	task automatic send(input logic [7:0] adr, op, typ, bnk, input logic [31:0] val, input logic bad,
		input int gap);
		logic [7:0] f[9];
		f = '{adr, op, typ, bnk, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
		for (int i = 0; i < 8; i++)
			f[8] += f[i];
		f[8] ^= {7'h00, bad};
		@(posedge hclk);
		for (int i = 0; i < 9; i++)
		begin
			rx_valid <= 1'b1;
			rx_byte <= f[i];
			do @(posedge hclk); while (!rx_ready);
			if (gap > 0 || i == 8)
			begin
				// a released line never shows the last byte
				rx_valid <= 1'b0;
				rx_byte <= ~f[i];
				repeat (gap) @(posedge hclk);
			end
		end
	endtask
endmodule
`default_nettype wire

// File: testbench/script_vm_accu_ops_properties.sv
// concurrent checks on the opcode executor outputs
`timescale 1ns/1ps
`default_nettype none
`include "accu_ops_regs.vh"
module script_vm_accu_ops_checker (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic reply_valid,
	input wire logic [7:0] reply_status,
	input wire logic [7:0] reply_opcode,
	input wire logic prog_running,
	input wire logic prog_reset,
	input wire logic axis_wr,
	input wire logic global_wr,
	input wire logic [7:0] global_bank,
	input wire logic wait_timeout,
	input wire logic alarm_event,
	input wire logic deviation_event,
	input wire logic position_event,
	input wire logic shutdown_event,
	input wire logic [`FLAG_WIDTH-1:0] error_flags
);
	wire logic [4:0] ev = {shutdown_event, position_event, deviation_event, alarm_event, wait_timeout};
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// ----------------
	// sequences and properties
	// ----------------
	sequence s_ok(op);
		reply_valid && reply_opcode == op && reply_status == `STAT_OK;
	endsequence
	// the write pulse may lead the reply by up to two cycles
	sequence s_wrote(w);
		w || $past(w) || $past(w, 2);
	endsequence
	property p_ok_status;
		reply_valid && reply_opcode inside {`OP_XCALC, `OP_TO_AXIS, `OP_CLEAR_FLAGS} |-> reply_status == `STAT_OK;
	endproperty
	a_ok_status: assert property (p_ok_status) else $error("bad status on compute reply");
	property p_stop_halts;
		s_ok(`OP_STOP) |-> !prog_running;
	endproperty
	a_stop_halts: assert property (p_stop_halts) else $error("program still runs after stop");
	property p_reset_app;
		s_ok(`OP_RESET_APP) |-> s_wrote(prog_reset) ##0 (error_flags == 5'h00 && !prog_running);
	endproperty
	a_reset_app: assert property (p_reset_app) else $error("reset command incomplete");
	property p_axis_write;
		s_ok(`OP_TO_AXIS) |-> s_wrote(axis_wr);
	endproperty
	a_axis_write: assert property (p_axis_write) else $error("axis write missing");
	property p_global_write;
		s_ok(`OP_TO_GLOBAL) |-> s_wrote(global_wr);
	endproperty
	a_global_write: assert property (p_global_write) else $error("global write missing");
	property p_bank_ok;
		global_wr |-> global_bank inside {`BANK_0, `BANK_2, `BANK_3};
	endproperty
	a_bank_ok: assert property (p_bank_ok) else $error("global write to refused bank");
	property p_event_flags;
		|ev |=> (error_flags & $past(ev)) == $past(ev);
	endproperty
	a_event_flags: assert property (p_event_flags) else $error("event did not set its flag");
	property p_clear_answered;
		|(~error_flags & $past(error_flags)) |-> ##[0:2] reply_valid;
	endproperty
	a_clear_answered: assert property (p_clear_answered) else $error("flag fell without command");
endmodule
bind script_vm_accu_ops script_vm_accu_ops_checker i_checker (.hclk, .hresetn, .reply_valid, .reply_status,
	.reply_opcode, .prog_running, .prog_reset, .axis_wr, .global_wr, .global_bank, .wait_timeout,
	.alarm_event, .deviation_event, .position_event, .shutdown_event, .error_flags);
`default_nettype wire

// File: testbench/tb_script_vm_accu_ops.sv
// self-checking bench for the accumulator opcode executor
`timescale 1ns/1ps
`default_nettype none
`include "accu_ops_regs.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
	$display("mismatch at %0t got %h expected %h", $time, g, e); end end
module tb_script_vm_accu_ops;
	localparam logic [7:0] dev_addr = 8'h01;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, prog_valid = 1'b0;
	logic [1:0] htrans = 2'b00;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0;
	logic [7:0] prog_opcode = 8'h00;
	logic [4:0] ev = 5'h00;
	logic [47:0] axis_seen = 48'h0, global_seen = 48'h0;
	int failures = 0, comparisons = 0, global_count = 0, reply_count = 0;
	wire hreadyout, hresp, rx_ready, rx_valid, reply_valid, prog_ready, prog_running;
	wire prog_reset, axis_wr, global_wr, irq;
	wire [7:0] rx_byte, reply_status, reply_opcode, axis_index, axis_motor, global_index, global_bank;
	wire [31:0] hrdata, axis_data, global_data;
	wire [4:0] error_flags;
	script_vm_accu_ops #(.MODULE_ADDR(dev_addr)) i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .rx_valid, .rx_byte,
		.rx_ready, .reply_valid, .reply_status, .reply_opcode, .prog_valid, .prog_opcode,
		.prog_type(8'h03), .prog_bank(8'h05), .prog_value(32'hffff_ffff), .prog_ready, .prog_running,
		.prog_reset, .axis_wr, .axis_index, .axis_motor, .axis_data, .global_wr, .global_index,
		.global_bank, .global_data, .wait_timeout(ev[0]), .alarm_event(ev[1]), .deviation_event(ev[2]),
		.position_event(ev[3]), .shutdown_event(ev[4]), .error_flags, .irq);
	host_frame_model i_host (.hclk, .rx_ready, .rx_valid, .rx_byte);
	always #5 hclk = ~hclk;
	always @(posedge hclk)
	begin
		global_count += global_wr;
		reply_count += reply_valid;
		if (axis_wr)
			axis_seen = {axis_index, axis_motor, axis_data};
		if (global_wr)
			global_seen = {global_index, global_bank, global_data};
	end
	// ----------------
	// bus and frame helpers
	// ----------------
	// a read compares the data phase word with d
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge hclk); while (!hreadyout);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (!hreadyout);
		if (!w) `CHK(hrdata, d)
		`CHK(hresp, 1'b0)
		@(posedge hclk);
	endtask
	task automatic cmd(input logic [7:0] op, t, b, st);
		int n;
		i_host.send(dev_addr, op, t, b, 32'h5a5a_0f0f, 1'b0, 0);
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (!reply_valid && n < 200);
		`CHK(reply_valid, 1'b1)
		`CHK(reply_status, st)
		`CHK(reply_opcode, op)
		repeat (2) @(posedge hclk);
	endtask
	task automatic t_reset;
		bus(1'b1, 8'h40, 32'hffff_ffff);
		bus(1'b0, 8'h40, 32'h0);
		bus(1'b0, `OFF_ACCU, 32'h0);
		bus(1'b0, `OFF_FLAGS, 32'h0);
		$display("reset test done");
	endtask
	task automatic t_calc;
		logic [31:0] a, x, ea;
		a = 32'hffff_fff9;
		for (int z = 0; z < 2; z++)
			for (int t = 0; t <= 10; t++)
			begin
				x = z ? 32'h0 : 32'h2;
				bus(1'b1, `OFF_ACCU, a);
				bus(1'b1, `OFF_XREG, x);
				cmd(`OP_XCALC, t[7:0], 8'h00, `STAT_OK);
				case (t)
					0: ea = a + x;
					1: ea = a - x;
					2: ea = a * x;
					// both arms signed, or the divide would run unsigned
					3: ea = x ? $signed(a) / $signed(x) : $signed(a);
					4: ea = x ? $signed(a) % $signed(x) : $signed(a);
					5: ea = a & x;
					6: ea = a | x;
					7: ea = a ^ x;
					8: ea = ~x;
					10: ea = x;
					default: ea = a;
				endcase
				bus(1'b0, `OFF_ACCU, ea);
				bus(1'b0, `OFF_XREG, (t == 9 || t == 10) ? a : x);
			end
		$display("compute test done");
	endtask
	task automatic t_params;
		int c;
		bus(1'b1, `OFF_ACCU, 32'h1234_5678);
		cmd(`OP_TO_AXIS, 8'h05, 8'h01, `STAT_OK);
		`CHK(axis_seen, {8'h05, 8'h01, 32'h1234_5678})
		for (int b = 0; b < 4; b++)
		begin
			c = global_count;
			cmd(`OP_TO_GLOBAL, 8'h2a, b[7:0], b == 1 ? `STAT_BAD_BANK : `STAT_OK);
			`CHK(global_count - c, b == 1 ? 0 : 1)
			if (b != 1) `CHK(global_seen, {8'h2a, b[7:0], 32'h1234_5678})
		end
		cmd(8'h40, 8'h00, 8'h00, `STAT_BAD_CMD);
		$display("parameter test done");
	endtask
	task automatic t_flags;
		logic [4:0] e;
		for (int t = 0; t <= 6; t++)
		begin
			ev <= 5'h1f;
			@(posedge hclk);
			ev <= 5'h00;
			repeat (3) @(posedge hclk);
			`CHK(error_flags, 5'h1f)
			e = (t == 0) ? 5'h00 : (t <= 5) ? 5'h1f & ~(5'h01 << (t - 1)) : 5'h1f;
			cmd(`OP_CLEAR_FLAGS, t[7:0], 8'h07, `STAT_OK);
			bus(1'b0, `OFF_FLAGS, {27'h0, e});
		end
		// replies raised the done bit, the event pulses the timeout bit
		bus(1'b0, `OFF_IRQ_STATUS, 32'hc);
		$display("flag test done");
	endtask
	task automatic t_link;
		int c;
		bus(1'b1, `OFF_IRQ_CLEAR, 32'hf);
		c = reply_count;
		i_host.send(dev_addr, `OP_XCALC, 8'h00, 8'h00, 32'h0, 1'b1, 2);
		i_host.send(dev_addr + 8'h01, `OP_XCALC, 8'h00, 8'h00, 32'h0, 1'b0, 0);
		repeat (50) @(posedge hclk);
		`CHK(reply_count - c, 0)
		bus(1'b0, `OFF_IRQ_STATUS, 32'h2);
		$display("link test done");
	endtask
	task automatic t_prog;
		bus(1'b1, `OFF_IRQ_ENABLE, 32'h1);
		bus(1'b1, `OFF_CTRL, 32'h1);
		`CHK(prog_running, 1'b1)
		bus(1'b0, `OFF_STATUS, 32'h1);
		prog_valid <= 1'b1;
		prog_opcode <= `OP_STOP;
		do @(posedge hclk); while (!prog_ready);
		prog_valid <= 1'b0;
		repeat (2) @(posedge hclk);
		`CHK({prog_running, irq}, 2'b01)
		bus(1'b1, `OFF_IRQ_ENABLE, 32'h0);
		`CHK(irq, 1'b0)
		bus(1'b1, `OFF_IRQ_CLEAR, 32'h1);
		bus(1'b1, `OFF_IRQ_ENABLE, 32'h1);
		`CHK(irq, 1'b0)
		bus(1'b1, `OFF_CTRL, 32'h1);
		cmd(`OP_STOP, 8'h07, 8'h05, `STAT_OK);
		`CHK(prog_running, 1'b0)
		bus(1'b1, `OFF_CTRL, 32'h1);
		`CHK(prog_running, 1'b1)
		bus(1'b1, `OFF_CTRL, 32'h2);
		`CHK(prog_running, 1'b0)
		bus(1'b1, `OFF_ACCU, 32'h5);
		bus(1'b1, `OFF_XREG, 32'h6);
		bus(1'b1, `OFF_CTRL, 32'h1);
		ev <= 5'h1f;
		@(posedge hclk);
		ev <= 5'h00;
		cmd(`OP_RESET_APP, 8'h00, 8'h00, `STAT_OK);
		`CHK({prog_running, error_flags}, 6'h00)
		bus(1'b0, `OFF_ACCU, 32'h0);
		bus(1'b0, `OFF_XREG, 32'h0);
		$display("program test done");
	endtask
	task automatic test_done;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset;
		t_calc;
		t_params;
		t_flags;
		t_link;
		t_prog;
		test_done;
	end
	// about forty times the expected run length
	initial
	begin
		#500000;
		failures++;
		test_done;
	end
endmodule
`default_nettype wire
